// [bench/swt_timer_top_tb_top.sv]
// Self-checking testbench for the split/wide timer control block.
`timescale 1ns/1ns
module swt_timer_top_tb_top;
  // ==========================================================================
  // Signals and design instance
  // ==========================================================================
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_bit_wr = 1'b0;
  logic [2:0] sfr_bit_sel = 3'h0;
  logic sfr_bit_val = 1'b0;
  logic sfr_rd = 1'b0;
  logic low_tick = 1'b0;
  logic high_tick = 1'b0;
  logic capture_pin = 1'b0;
  logic [1:0] capture_edge = swt_pkg::EDGE_RISE;
  logic [7:0] sfr_rdata_out;
  logic irq_out;
  int error_cnt = 0;
  int num_checks = 0;
  int cycle_cnt = 0;

  swt_timer_top dut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .sfr_addr_in(sfr_addr),
    .sfr_wr_in(sfr_wr),
    .sfr_wdata_in(sfr_wdata),
    .sfr_bit_wr_in(sfr_bit_wr),
    .sfr_bit_sel_in(sfr_bit_sel),
    .sfr_bit_val_in(sfr_bit_val),
    .sfr_rd_in(sfr_rd),
    .low_tick_in(low_tick),
    .high_tick_in(high_tick),
    .capture_pin_in(capture_pin),
    .capture_edge_in(capture_edge),
    .sfr_rdata_out(sfr_rdata_out),
    .irq_out(irq_out)
  );

  always #20 clk_in = ~clk_in;

  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic print_verdict;
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge clk_in) begin
    cycle_cnt++;
    if (cycle_cnt == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_wr = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : wr

  task automatic bit_wr(input logic [2:0] sel, input logic val);
    sfr_addr = swt_pkg::ADDR_CTRL;
    sfr_bit_sel = sel;
    sfr_bit_val = val;
    sfr_bit_wr = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_bit_wr = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : bit_wr

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_rd = 1'b0;
    @(posedge clk_in);
    #1;
    num_checks++;
    if (sfr_rdata_out !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t read %h gave %h expected %h", $time, a, sfr_rdata_out, exp);
    end
  endtask : rd_chk

  task automatic irq_chk(input logic exp);
    num_checks++;
    if (irq_out !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t interrupt request is %b expected %b", $time, irq_out, exp);
    end
  endtask : irq_chk

  task automatic tick(input logic lo, input logic hi);
    low_tick = lo;
    high_tick = hi;
    @(posedge clk_in);
    #1;
    low_tick = 1'b0;
    high_tick = 1'b0;
    @(posedge clk_in);
    #1;
  endtask : tick

  task automatic pin_set(input logic v);
    capture_pin = v;
    repeat (6) @(posedge clk_in);
    #1;
  endtask : pin_set

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic test_registers;
    for (int a = 8'hC8; a <= 8'hCD; a++) begin
      if (a != 8'hC9) begin
        rd_chk(a[7:0], 8'h00);
      end
    end
    wr(8'hC8, 8'hA5);
    rd_chk(8'hC8, 8'hA5);
    wr(8'hC7, 8'hFF);
    rd_chk(8'hC7, 8'h00);
    wr(8'hC8, 8'h00);
    for (int i = 0; i < 8; i++) begin
      bit_wr(i[2:0], 1'b1);
      rd_chk(8'hC8, 8'hFF >> (7 - i));
    end
    for (int i = 0; i < 8; i++) begin
      bit_wr(i[2:0], 1'b0);
      rd_chk(8'hC8, 8'hFF << (i + 1));
    end
  endtask : test_registers

  task automatic test_wide_timer;
    wr(8'hCA, 8'hF0);
    wr(8'hCB, 8'h12);
    wr(8'hCC, 8'hFE);
    wr(8'hCD, 8'hFF);
    wr(8'hC8, 8'h01);
    tick(1'b1, 1'b0);
    tick(1'b1, 1'b0);
    rd_chk(8'hCC, 8'hF0);
    rd_chk(8'hCD, 8'h12);
    repeat (20) @(posedge clk_in);
    #1;
    rd_chk(8'hC8, 8'hC1);
    irq_chk(1'b1);
    bit_wr(3'h7, 1'b0);
    irq_chk(1'b0);
    bit_wr(3'h5, 1'b1);
    irq_chk(1'b1);
    bit_wr(3'h6, 1'b0);
    irq_chk(1'b0);
    bit_wr(3'h1, 1'b1);
    tick(1'b0, 1'b1);
    rd_chk(8'hCC, 8'hF0);
    rd_chk(8'hCD, 8'h12);
  endtask : test_wide_timer

  task automatic test_split_timer;
    wr(8'hC8, 8'h13);
    wr(8'hCA, 8'h05);
    wr(8'hCB, 8'h07);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    tick(1'b1, 1'b0);
    rd_chk(8'hCC, 8'h05);
    rd_chk(8'hCD, 8'hFF);
    rd_chk(8'hC8, 8'h53);
    tick(1'b0, 1'b1);
    rd_chk(8'hCD, 8'h07);
    rd_chk(8'hC8, 8'hD3);
  endtask : test_split_timer

  task automatic test_wide_capture;
    wr(8'hCA, 8'h11);
    wr(8'hCB, 8'h22);
    wr(8'hCC, 8'h56);
    wr(8'hCD, 8'h34);
    wr(8'hC8, 8'h08);
    pin_set(1'b1);
    rd_chk(8'hC8, 8'h08);
    rd_chk(8'hCA, 8'h11);
    pin_set(1'b0);
    wr(8'hC8, 8'h04);
    pin_set(1'b1);
    rd_chk(8'hCA, 8'h56);
    rd_chk(8'hCB, 8'h34);
    rd_chk(8'hC8, 8'h84);
    pin_set(1'b0);
    wr(8'hC8, 8'h05);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'hFF);
    tick(1'b1, 1'b0);
    rd_chk(8'hCC, 8'h00);
    rd_chk(8'hC8, 8'h45);
  endtask : test_wide_capture

  task automatic test_edge_modes;
    for (int m = 0; m < 4; m++) begin
      capture_edge = m[1:0];
      wr(8'hC8, 8'h1C);
      pin_set(1'b1);
      rd_chk(8'hC8, (m == 1 || m == 3) ? 8'hDC : 8'h1C);
      wr(8'hC8, 8'h1C);
      pin_set(1'b0);
      rd_chk(8'hC8, (m >= 2) ? 8'hDC : 8'h1C);
    end
  endtask : test_edge_modes

  task automatic test_hw_priority;
    wr(8'hC8, 8'h41);
    wr(8'hCC, 8'hFF);
    wr(8'hCD, 8'h00);
    sfr_addr = swt_pkg::ADDR_CTRL;
    sfr_bit_sel = 3'h6;
    sfr_bit_val = 1'b0;
    sfr_bit_wr = 1'b1;
    low_tick = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_bit_wr = 1'b0;
    low_tick = 1'b0;
    rd_chk(8'hC8, 8'h41);
    wr(8'hCC, 8'hFF);
    sfr_addr = swt_pkg::ADDR_CTRL;
    sfr_wdata = 8'h01;
    sfr_wr = 1'b1;
    low_tick = 1'b1;
    @(posedge clk_in);
    #1;
    sfr_wr = 1'b0;
    low_tick = 1'b0;
    rd_chk(8'hC8, 8'h41);
    rd_chk(8'hCD, 8'h02);
  endtask : test_hw_priority

  task automatic test_reset;
    wr(8'hC8, 8'hA0);
    irq_chk(1'b1);
    rst_n_in = 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
    num_checks++;
    if (irq_out !== 1'b0 || sfr_rdata_out !== 8'h00) begin
      error_cnt++;
      $display("[FAIL] %0t reset left outputs at %b %h", $time, irq_out, sfr_rdata_out);
    end
    rst_n_in = 1'b1;
    rd_chk(8'hC8, 8'h00);
    rd_chk(8'hCB, 8'h00);
  endtask : test_reset

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    repeat (12) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    test_registers();
    test_wide_timer();
    test_split_timer();
    test_wide_capture();
    test_edge_modes();
    test_hw_priority();
    test_reset();
    print_verdict();
  end
endmodule : swt_timer_top_tb_top

// [rtl/swt_edge_detect.sv]
// Synchroniser and programmable edge detector for the capture event pin.
`timescale 1ns/1ns
module swt_edge_detect (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic pin_in,
  input wire logic [1:0] edge_mode_in,
  output logic event_out
);
  logic [1:0] sync_reg;
  logic [1:0] sync_next;
  logic prev_reg;
  logic prev_next;
  logic event_reg;
  logic event_next;
  logic rise;
  logic fall;

  // ==========================================================================
  // Edge selection
  // ==========================================================================
  always_comb begin
    sync_next = {sync_reg[0], pin_in};
    prev_next = sync_reg[1];
    rise = sync_reg[1] & ~prev_reg;
    fall = ~sync_reg[1] & prev_reg;
    event_next = 1'b0;
    if (edge_mode_in == swt_pkg::EDGE_RISE) begin
      event_next = rise;
    end else if (edge_mode_in == swt_pkg::EDGE_FALL) begin
      event_next = fall;
    end else if (edge_mode_in == swt_pkg::EDGE_BOTH) begin
      event_next = rise | fall;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      sync_reg <= 2'h0;
      prev_reg <= 1'b0;
      event_reg <= 1'b0;
    end else begin
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      event_reg <= event_next;
    end
  end

  assign event_out = event_reg;
endmodule : swt_edge_detect

// [rtl/swt_half_counter.sv]
// Next-value logic for one 8-bit half of the timer counter.
`timescale 1ns/1ns
module swt_half_counter #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] count_in,
  input wire logic [WIDTH-1:0] reload_in,
  input wire logic inc_in,
  input wire logic load_in,
  output logic [WIDTH-1:0] count_out,
  output logic wrap_out
);
  // ==========================================================================
  // Increment, wrap and reload
  // ==========================================================================
  always_comb begin
    wrap_out = inc_in & (&count_in);
    count_out = count_in;
    if (load_in) begin
      count_out = reload_in;
    end else if (inc_in) begin
      count_out = count_in + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end
endmodule : swt_half_counter

// [rtl/swt_pkg.sv]
// Package with addresses, field positions, reset values and codes of the split/wide timer.
package swt_pkg;
  // ==========================================================================
  // Register addresses
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL = 8'hC8;
  localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
  localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
  localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
  localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;
  // ==========================================================================
  // Control register fields
  // ==========================================================================
  localparam int BIT_HIGH_FLAG = 7;
  localparam int BIT_LOW_FLAG = 6;
  localparam int BIT_LOW_IRQ_EN = 5;
  localparam int BIT_SPLIT = 4;
  localparam int BIT_HIGH_CAP = 3;
  localparam int BIT_LOW_CAP = 2;
  localparam int BIT_HIGH_RUN = 1;
  localparam int BIT_LOW_RUN = 0;
  // ==========================================================================
  // Reset values and constants
  // ==========================================================================
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
  localparam int SYNC_STAGES = 2;
  // ==========================================================================
  // Capture edge selection codes
  // ==========================================================================
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage : swt_pkg

// [rtl/swt_timer_top.sv]
// Control, flags and counters of a 16-bit timer that splits into two 8-bit halves.
// Notes on behaviour
// - High flag sets on high half overflow in timer mode, wide timer overflow, or high-half or wide capture.
// - High flag is cleared only by software writing zero.
// - Low flag sets on low overflow in timer mode or low capture.
// - Wide timer mode still sets low flag on every low byte overflow.
// - Wide capture mode sets low flag on 16-bit overflow, a seventeenth bit.
// - Wide capture mode sets high flag on each capture event.
// - Interrupt is high flag OR (low flag AND low interrupt enable).
// - Split bit zero gives one 16-bit timer under low-half controls.
// - High capture select acts only when split; ignored in wide configuration.
// - Low capture select makes low half, or whole wide timer, capture.
// - Control register at C8, bit addressable, all bits read/write, reset zero.
// - High run enables high byte when split; low run enables low or whole.
// - Capture event is the programmed rise, fall or both edge on the pin.
// - Wide timer wrap from all ones loads the 16-bit reload pair.
// - Capture copies count bytes into reload bytes, even while stopped.
`timescale 1ns/1ns
module swt_timer_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_bit_wr_in,
  input wire logic [2:0] sfr_bit_sel_in,
  input wire logic sfr_bit_val_in,
  input wire logic sfr_rd_in,
  input wire logic low_tick_in,
  input wire logic high_tick_in,
  input wire logic capture_pin_in,
  input wire logic [1:0] capture_edge_in,
  output logic [7:0] sfr_rdata_out,
  output logic irq_out
);
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [7:0] rl_low_reg;
  logic [7:0] rl_low_next;
  logic [7:0] rl_high_reg;
  logic [7:0] rl_high_next;
  logic [7:0] cnt_low_reg;
  logic [7:0] cnt_low_next;
  logic [7:0] cnt_high_reg;
  logic [7:0] cnt_high_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] sw_ctrl;
  logic [7:0] cnt_low_calc;
  logic [7:0] cnt_high_calc;
  logic cap_event;
  logic split;
  logic low_cap;
  logic high_cap;
  logic wide_timer;
  logic wide_cap;
  logic inc_low;
  logic inc_high;
  logic wrap_low;
  logic wrap_high;
  logic load_low;
  logic load_high;
  logic cap_low;
  logic cap_high;
  logic set_high;
  logic set_low;
  logic ctrl_sel;
  logic bit_wr;

  // ==========================================================================
  // Capture event
  // ==========================================================================
  swt_edge_detect u_edge (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .pin_in(capture_pin_in),
    .edge_mode_in(capture_edge_in),
    .event_out(cap_event)
  );

  // ==========================================================================
  // Mode decode
  // ==========================================================================
  assign split = ctrl_reg[swt_pkg::BIT_SPLIT];
  assign low_cap = ctrl_reg[swt_pkg::BIT_LOW_CAP];
  assign high_cap = split & ctrl_reg[swt_pkg::BIT_HIGH_CAP];
  assign wide_timer = ~split & ~low_cap;
  assign wide_cap = ~split & low_cap;
  assign inc_low = ctrl_reg[swt_pkg::BIT_LOW_RUN] & low_tick_in;
  assign inc_high = split ? (ctrl_reg[swt_pkg::BIT_HIGH_RUN] & high_tick_in)
                          : wrap_low;
  assign load_low = split ? (~low_cap & wrap_low) : (wide_timer & wrap_high);
  assign load_high = split ? (~high_cap & wrap_high) : (wide_timer & wrap_high);
  assign cap_low = cap_event & low_cap;
  assign cap_high = cap_event & (split ? high_cap : low_cap);

  swt_half_counter #(.WIDTH(8)) u_low (
    .count_in(cnt_low_reg),
    .reload_in(rl_low_reg),
    .inc_in(inc_low),
    .load_in(load_low),
    .count_out(cnt_low_calc),
    .wrap_out(wrap_low)
  );

  swt_half_counter #(.WIDTH(8)) u_high (
    .count_in(cnt_high_reg),
    .reload_in(rl_high_reg),
    .inc_in(inc_high),
    .load_in(load_high),
    .count_out(cnt_high_calc),
    .wrap_out(wrap_high)
  );

  // ==========================================================================
  // Flag events
  // ==========================================================================
  always_comb begin
    set_high = 1'b0;
    set_low = 1'b0;
    if (split) begin
      set_high = high_cap ? cap_event : wrap_high;
      set_low = low_cap ? cap_event : wrap_low;
    end else if (low_cap) begin
      set_high = cap_event;
      set_low = wrap_high;
    end else begin
      set_high = wrap_high;
      set_low = wrap_low;
    end
  end

  // ==========================================================================
  // Register file
  // ==========================================================================
  assign ctrl_sel = sfr_addr_in == swt_pkg::ADDR_CTRL;
  assign bit_wr = sfr_bit_wr_in & ctrl_sel;

  always_comb begin
    sw_ctrl = ctrl_reg;
    if (sfr_wr_in && ctrl_sel) begin
      sw_ctrl = sfr_wdata_in;
    end else if (bit_wr) begin
      sw_ctrl[sfr_bit_sel_in] = sfr_bit_val_in;
    end
    ctrl_next = sw_ctrl;
    ctrl_next[swt_pkg::BIT_HIGH_FLAG] = sw_ctrl[swt_pkg::BIT_HIGH_FLAG] | set_high;
    ctrl_next[swt_pkg::BIT_LOW_FLAG] = sw_ctrl[swt_pkg::BIT_LOW_FLAG] | set_low;
    rl_low_next = rl_low_reg;
    rl_high_next = rl_high_reg;
    if (sfr_wr_in && sfr_addr_in == swt_pkg::ADDR_RELOAD_LOW) begin
      rl_low_next = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == swt_pkg::ADDR_RELOAD_HIGH) begin
      rl_high_next = sfr_wdata_in;
    end
    if (cap_low) begin
      rl_low_next = cnt_low_reg;
    end
    if (cap_high) begin
      rl_high_next = cnt_high_reg;
    end
    cnt_low_next = cnt_low_calc;
    cnt_high_next = cnt_high_calc;
    if (sfr_wr_in && sfr_addr_in == swt_pkg::ADDR_COUNT_LOW) begin
      cnt_low_next = sfr_wdata_in;
    end
    if (sfr_wr_in && sfr_addr_in == swt_pkg::ADDR_COUNT_HIGH) begin
      cnt_high_next = sfr_wdata_in;
    end
    rdata_next = rdata_reg;
    if (sfr_rd_in) begin
      if (ctrl_sel) begin
        rdata_next = ctrl_reg;
      end else if (sfr_addr_in == swt_pkg::ADDR_RELOAD_LOW) begin
        rdata_next = rl_low_reg;
      end else if (sfr_addr_in == swt_pkg::ADDR_RELOAD_HIGH) begin
        rdata_next = rl_high_reg;
      end else if (sfr_addr_in == swt_pkg::ADDR_COUNT_LOW) begin
        rdata_next = cnt_low_reg;
      end else if (sfr_addr_in == swt_pkg::ADDR_COUNT_HIGH) begin
        rdata_next = cnt_high_reg;
      end else begin
        rdata_next = swt_pkg::BYTE_RESET;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      ctrl_reg <= swt_pkg::CTRL_RESET;
      rl_low_reg <= swt_pkg::BYTE_RESET;
      rl_high_reg <= swt_pkg::BYTE_RESET;
      cnt_low_reg <= swt_pkg::BYTE_RESET;
      cnt_high_reg <= swt_pkg::BYTE_RESET;
      rdata_reg <= swt_pkg::BYTE_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
      rl_low_reg <= rl_low_next;
      rl_high_reg <= rl_high_next;
      cnt_low_reg <= cnt_low_next;
      cnt_high_reg <= cnt_high_next;
      rdata_reg <= rdata_next;
    end
  end

  assign sfr_rdata_out = rdata_reg;
  assign irq_out = ctrl_reg[swt_pkg::BIT_HIGH_FLAG] |
                   (ctrl_reg[swt_pkg::BIT_LOW_FLAG] & ctrl_reg[swt_pkg::BIT_LOW_IRQ_EN]);

  // ==========================================================================
  // Checks
  // ==========================================================================
  logic no_cnt_wr;
  assign no_cnt_wr = ~(sfr_wr_in &&
                       (sfr_addr_in == swt_pkg::ADDR_COUNT_LOW ||
                        sfr_addr_in == swt_pkg::ADDR_COUNT_HIGH));

  sequence wide_wrap_s;
    wide_timer && wrap_high && no_cnt_wr;
  endsequence

  sequence loaded_s;
    cnt_low_reg == $past(rl_low_reg) && cnt_high_reg == $past(rl_high_reg);
  endsequence

  irq_combine_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    irq_out == (ctrl_reg[7] | (ctrl_reg[6] & ctrl_reg[5])))
    else $error("Interrupt request does not match flags.");

  high_sticky_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $fell(ctrl_reg[swt_pkg::BIT_HIGH_FLAG]) |-> $past(ctrl_sel && (sfr_wr_in || sfr_bit_wr_in)))
    else $error("High flag cleared without a software write.");

  wide_cap_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wide_cap && cap_event) |=> ctrl_reg[swt_pkg::BIT_HIGH_FLAG])
    else $error("Wide capture did not set the high flag.");

  wide_low_ovf_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wide_timer && wrap_low) |=> ctrl_reg[swt_pkg::BIT_LOW_FLAG])
    else $error("Low byte overflow did not set the low flag.");

  wide_bit17_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wide_cap && wrap_high) |=> ctrl_reg[swt_pkg::BIT_LOW_FLAG] && cnt_high_reg == 8'h00)
    else $error("Wide capture overflow did not set the low flag.");

  wide_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    wide_wrap_s |=> loaded_s ##0 ctrl_reg[swt_pkg::BIT_HIGH_FLAG])
    else $error("Wide wrap did not load the reload pair.");

  capture_copy_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wide_cap && cap_event) |=> rl_low_reg == $past(cnt_low_reg) &&
                                rl_high_reg == $past(cnt_high_reg))
    else $error("Capture did not copy the counter.");

  split_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (split && !high_cap && wrap_high && no_cnt_wr) |=>
      cnt_high_reg == $past(rl_high_reg) && ctrl_reg[swt_pkg::BIT_HIGH_FLAG])
    else $error("Split high half did not reload on wrap.");

  stopped_hold_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!split && !ctrl_reg[swt_pkg::BIT_LOW_RUN] && no_cnt_wr) |=>
      $stable(cnt_low_reg) && $stable(cnt_high_reg))
    else $error("Stopped wide timer changed its count.");

  set_wins_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (set_low && sfr_wr_in && ctrl_sel && !sfr_wdata_in[6]) |=> ctrl_reg[6])
    else $error("Software clear overrode a hardware set.");

  split_low_cap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (split && low_cap && cap_event) |=> ctrl_reg[6] && rl_low_reg == $past(cnt_low_reg))
    else $error("Split low capture did not set flag and copy.");

  sequence split_high_cap_s;
    split && high_cap && cap_event;
  endsequence

  split_high_cap_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    split_high_cap_s |=>
      ctrl_reg[swt_pkg::BIT_HIGH_FLAG] && rl_high_reg == $past(cnt_high_reg))
    else $error("Split high capture did not set flag and copy.");

  split_low_reload_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (split && !low_cap && wrap_low && no_cnt_wr) |=>
      cnt_low_reg == $past(rl_low_reg) && ctrl_reg[swt_pkg::BIT_LOW_FLAG])
    else $error("Split low half did not reload on wrap.");

  high_cap_ignored_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (wide_timer && ctrl_reg[swt_pkg::BIT_HIGH_CAP] && cap_event && !wrap_high && !sfr_wr_in &&
     !sfr_bit_wr_in) |=> $stable(ctrl_reg[swt_pkg::BIT_HIGH_FLAG]) && $stable(rl_high_reg))
    else $error("High capture select acted in wide configuration.");

  split_high_run_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (split && !ctrl_reg[swt_pkg::BIT_HIGH_RUN] && no_cnt_wr) |=> $stable(cnt_high_reg))
    else $error("Stopped split high half changed its count.");

  bit_write_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (bit_wr && !sfr_wr_in && sfr_bit_sel_in < 3'h6) |=>
      ctrl_reg[$past(sfr_bit_sel_in)] == $past(sfr_bit_val_in))
    else $error("Single-bit write did not land.");

  wide_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (!split && wrap_low && !wrap_high && no_cnt_wr) |=>
      cnt_high_reg == $past(cnt_high_reg) + 8'h01)
    else $error("Low byte overflow did not carry into the high byte.");
endmodule : swt_timer_top
